// file: inc/psl_pkg.sv
/*
 * Constants, carrier structs and state enum for the pin, status and strap logic.
 * Assumes a single 250 MHz system clock and pin inputs synchronised inside the block.
 */
// Overview of operation
// - Port LED pins are driven low to light, high to darken.
// - LED select bit 9 clear: A speed, B link/act; set: A activity, B link.
// - Link steady, activity blinks, combined on or blinking, speed lit at 100 only.
// - Pull level on LED A pin is latched at reset as 16-/8-bit bus width.
// - Wake output asserts while any enabled wake event is present.
// - Wake output active low by default; polarity input selects its level.
// - Interrupt pin pulled low while any interrupt status bit is set, else released.
// - EEPROM data pin is only read, never driven; its pull level at reset means EEPROM present.
// - Bus speed code 11 gives a 4 us EEPROM serial clock period during loading.
// - Bus speed code 00 gives an 800 ns EEPROM serial clock period during loading.
// - Pull level on EEPROM clock pin at reset selects big or little endian.
// - EEPROM serial clock output is used to read configuration data.
package psl_pkg;
    localparam int         CLK_PERIOD_NS     = 4;
    localparam int         EE_SLOW_PERIOD_NS = 4000;
    localparam int         EE_FAST_PERIOD_NS = 800;
    localparam logic [9:0] EE_SLOW_HALF      = 10'(EE_SLOW_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [9:0] EE_FAST_HALF      = 10'(EE_FAST_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [1:0] BUS_SPEED_25      = 2'h3;
    localparam logic [1:0] BUS_SPEED_125     = 2'h0;
    localparam int         LED_SEL_BIT       = 9;
    localparam int         BLINK_PERIOD_NS   = 50000000;
    localparam int         BLINK_CYC_DEF     = BLINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int         EE_WORD_BITS      = 16;
    localparam logic [1:0] STRAP_WAIT        = 2'h2;
    localparam int         WAKE_W            = 4;
    localparam int         IRQ_W             = 16;
    localparam logic [5:0] PIN_SYNC_RST      = 6'h3f;
    // Synchronised pin vector positions
    localparam int         PIN_LED_A         = 5;
    localparam int         PIN_EE_DATA       = 4;
    localparam int         PIN_EE_CLK        = 3;
    localparam int         PIN_RD_N          = 2;
    localparam int         PIN_CS_N          = 1;
    localparam int         PIN_CMD           = 0;

    typedef struct packed {
        logic up;
        logic speed_100;
        logic activity;
    } psl_link_s;

    typedef struct packed {
        logic bus_16bit;
        logic eeprom_present;
        logic big_endian;
    } psl_strap_s;

    typedef struct packed {
        logic sel;
        logic rd;
        logic cmd_addr;
    } psl_host_s;

    typedef enum logic [1:0] {
        PSL_STRAP,
        PSL_LOAD,
        PSL_RUN
    } psl_state_e;
endpackage

// file: src/psl_pin_logic.sv
/*
 * Pin-level status, strap latching and EEPROM clocking for a single-port controller.
 * Assumes link, wake and interrupt status come from logic on clk_sys; pins are asynchronous.
 */
`timescale 1ns/100ps
module psl_pin_logic #(
    parameter int BLINK_CYC = psl_pkg::BLINK_CYC_DEF
) (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         clk_en,
    input  wire psl_pkg::psl_link_s           link_status,
    input  wire logic [15:0]                  chip_global_control,
    input  wire logic                         power_mgmt_polarity,
    input  wire logic [psl_pkg::WAKE_W-1:0]   wake_events,
    input  wire logic [psl_pkg::WAKE_W-1:0]   wake_enable,
    input  wire logic [psl_pkg::IRQ_W-1:0]    irq_status,
    input  wire logic [1:0]                   onchip_bus_speed_ctrl,
    input  wire logic                         ee_load_req,
    input  wire logic                         port_indicator_a_i,
    output logic                              port_indicator_a_o,
    output logic                              port_indicator_a_oe_n,
    output logic                              port_indicator_b,
    output logic                              wake_event_out,
    output logic                              host_irq_n_o,
    output logic                              host_irq_n_oe_n,
    input  wire logic                         read_strobe_n,
    input  wire logic                         chip_select_n,
    input  wire logic                         cmd_type,
    input  wire logic                         eeprom_serial_data_i,
    output logic                              eeprom_serial_data_o,
    output logic                              eeprom_serial_data_oe_n,
    input  wire logic                         eeprom_serial_clock_i,
    output logic                              eeprom_serial_clock_o,
    output logic                              eeprom_serial_clock_oe_n,
    output psl_pkg::psl_strap_s               strap,
    output psl_pkg::psl_host_s                host_access,
    output logic [psl_pkg::EE_WORD_BITS-1:0]  ee_word,
    output logic                              ee_done
);
    import psl_pkg::*;

    localparam logic [23:0] BLINK_LAST = 24'(BLINK_CYC - 1);
    localparam logic [23:0] BLINK_HALF = 24'(BLINK_CYC / 2);

    psl_state_e  state_r;
    logic [1:0]  strap_cnt_r;
    logic [5:0]  pin_meta_r;
    logic [5:0]  pin_sync_r;
    logic [9:0]  half_cnt_r;
    logic [3:0]  bit_cnt_r;
    logic [23:0] blink_cnt_r;
    logic        ee_tick;
    logic        ee_last;
    logic        act_lit;
    logic        led_a_on;
    logic        led_b_on;

    // Half period of the EEPROM clock; unlisted speed codes fall back to the slow rate
    function automatic logic [9:0] half_for(input logic [1:0] spd);
        return (spd == BUS_SPEED_125) ? EE_FAST_HALF : EE_SLOW_HALF;
    endfunction

    // Two-stage synchroniser for every pin input
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta_r <= PIN_SYNC_RST;
            pin_sync_r <= PIN_SYNC_RST;
        end else if (clk_en) begin
            pin_meta_r <= {port_indicator_a_i, eeprom_serial_data_i, eeprom_serial_clock_i,
                           read_strobe_n, chip_select_n, cmd_type};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign ee_tick = (state_r == PSL_LOAD) && (half_cnt_r == half_for(onchip_bus_speed_ctrl) - 10'h001);
    assign ee_last = ee_tick && !eeprom_serial_clock_o && (bit_cnt_r == 4'(EE_WORD_BITS - 1));

    // Sequencer: strap capture, optional EEPROM load, then normal running
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r     <= PSL_STRAP;
            strap_cnt_r <= 2'h0;
            strap       <= '0;
        end else if (clk_en) begin
            unique case (state_r)
                PSL_STRAP: begin
                    // Wait out the synchroniser so reset-time levels are not taken
                    if (strap_cnt_r == STRAP_WAIT) begin
                        strap.bus_16bit      <= pin_sync_r[PIN_LED_A];
                        strap.eeprom_present <= pin_sync_r[PIN_EE_DATA];
                        strap.big_endian     <= pin_sync_r[PIN_EE_CLK];
                        state_r <= pin_sync_r[PIN_EE_DATA] ? PSL_LOAD : PSL_RUN;
                    end else begin
                        strap_cnt_r <= strap_cnt_r + 2'h1;
                    end
                end
                PSL_LOAD: begin
                    if (ee_last) begin
                        state_r <= PSL_RUN;
                    end
                end
                PSL_RUN: begin
                    if (ee_load_req && strap.eeprom_present) begin
                        state_r <= PSL_LOAD;
                    end
                end
            endcase
        end
    end

    // EEPROM serial clock and data capture on rising clock edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            half_cnt_r               <= 10'h000;
            bit_cnt_r                <= 4'h0;
            eeprom_serial_clock_o    <= 1'b0;
            eeprom_serial_clock_oe_n <= 1'b1;
            eeprom_serial_data_o     <= 1'b0;
            eeprom_serial_data_oe_n  <= 1'b1;
            ee_word                  <= '0;
            ee_done                  <= 1'b0;
        end else if (clk_en) begin
            // Clock pin stays released until its strap has been taken
            eeprom_serial_clock_oe_n <= (state_r == PSL_STRAP);
            // Data pin only read here; command framing is outside this block
            eeprom_serial_data_oe_n  <= 1'b1;
            if (state_r != PSL_LOAD) begin
                half_cnt_r            <= 10'h000;
                bit_cnt_r             <= 4'h0;
                eeprom_serial_clock_o <= 1'b0;
                if (state_r == PSL_RUN && ee_load_req && strap.eeprom_present) begin
                    ee_done <= 1'b0;
                end
            end else if (ee_tick) begin
                half_cnt_r            <= 10'h000;
                eeprom_serial_clock_o <= !eeprom_serial_clock_o;
                if (!eeprom_serial_clock_o) begin
                    ee_word   <= {ee_word[EE_WORD_BITS-2:0], pin_sync_r[PIN_EE_DATA]};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (ee_last) begin
                        ee_done <= 1'b1;
                    end
                end
            end else begin
                half_cnt_r <= half_cnt_r + 10'h001;
            end
        end
    end

    // Activity stretch: lit for the first half of each blink, dark for the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blink_cnt_r <= 24'h000000;
        end else if (clk_en) begin
            if (blink_cnt_r != 24'h000000) begin
                blink_cnt_r <= blink_cnt_r - 24'h000001;
            end else if (link_status.activity) begin
                blink_cnt_r <= BLINK_LAST;
            end
        end
    end

    assign act_lit  = blink_cnt_r > BLINK_HALF;
    assign led_a_on = chip_global_control[LED_SEL_BIT] ? act_lit
                                                        : (link_status.up && link_status.speed_100);
    assign led_b_on = chip_global_control[LED_SEL_BIT] ? link_status.up
                                                        : (link_status.up && !act_lit);

    // LED pins, active low; LED A released while its strap is sampled
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_indicator_a_o    <= 1'b1;
            port_indicator_a_oe_n <= 1'b1;
            port_indicator_b      <= 1'b1;
        end else if (clk_en) begin
            port_indicator_a_o    <= !led_a_on;
            port_indicator_a_oe_n <= (state_r == PSL_STRAP);
            port_indicator_b      <= !led_b_on;
        end
    end

    // Wake and interrupt pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake_event_out  <= 1'b1;
            host_irq_n_o    <= 1'b0;
            host_irq_n_oe_n <= 1'b1;
        end else if (clk_en) begin
            wake_event_out  <= (|(wake_events & wake_enable)) ? power_mgmt_polarity
                                                              : !power_mgmt_polarity;
            host_irq_n_o    <= 1'b0;
            host_irq_n_oe_n <= !(|irq_status);
        end
    end

    // Host strobe qualification; nothing counts without chip select
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            host_access <= '0;
        end else if (clk_en) begin
            host_access.sel      <= !pin_sync_r[PIN_CS_N];
            host_access.rd       <= !pin_sync_r[PIN_CS_N] && !pin_sync_r[PIN_RD_N];
            host_access.cmd_addr <= !pin_sync_r[PIN_CS_N] && pin_sync_r[PIN_CMD];
        end
    end

    // Checking helpers: cycles since the last EEPROM clock change
    logic [9:0] gap_cnt_r;
    always_ff @(posedge clk_sys) begin
        if (rst || state_r != PSL_LOAD) begin
            gap_cnt_r <= 10'h000;
        end else if (clk_en) begin
            gap_cnt_r <= ee_tick ? 10'h000 : gap_cnt_r + 10'h001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || !clk_en);

    led_speed_a: assert property (
        !chip_global_control[LED_SEL_BIT] && link_status.up && link_status.speed_100 |=> !port_indicator_a_o)
        else $error("Speed LED dark at 100");
    led_ten_a: assert property (
        !chip_global_control[LED_SEL_BIT] && !link_status.speed_100 |=> port_indicator_a_o)
        else $error("Speed LED lit at 10");
    link_steady_a: assert property (
        chip_global_control[LED_SEL_BIT] && link_status.up |=> !port_indicator_b)
        else $error("Link LED not lit");
    blink_start_a: assert property (
        blink_cnt_r == 24'h000000 && link_status.activity
        && chip_global_control[LED_SEL_BIT] ##1 chip_global_control[LED_SEL_BIT]
        |=> !port_indicator_a_o) else $error("Activity did not light LED");
    strap_take_a: assert property (
        state_r == PSL_STRAP && strap_cnt_r == STRAP_WAIT
        |=> strap.bus_16bit == $past(pin_sync_r[PIN_LED_A])
            && strap.big_endian == $past(pin_sync_r[PIN_EE_CLK])) else $error("Strap not latched");
    strap_hold_a: assert property (state_r != PSL_STRAP |=> $stable(strap))
        else $error("Strap changed after latch");
    load_gate_a: assert property (
        state_r == PSL_STRAP ##1 state_r == PSL_LOAD |-> strap.eeprom_present)
        else $error("Load without EEPROM");
    wake_level_a: assert property (
        |(wake_events & wake_enable) |=> wake_event_out == $past(power_mgmt_polarity))
        else $error("Wake not asserted");
    wake_idle_a: assert property (
        !(|(wake_events & wake_enable)) |=> wake_event_out != $past(power_mgmt_polarity))
        else $error("Wake asserted idle");
    irq_drive_a: assert property (|irq_status |=> !host_irq_n_oe_n && !host_irq_n_o)
        else $error("Interrupt not driven");
    ee_fast_a: assert property (
        ee_tick && onchip_bus_speed_ctrl == BUS_SPEED_125 |-> gap_cnt_r == EE_FAST_HALF - 10'h001)
        else $error("Fast EEPROM half period wrong");
    ee_slow_a: assert property (
        ee_tick && onchip_bus_speed_ctrl == BUS_SPEED_25 |-> gap_cnt_r == EE_SLOW_HALF - 10'h001)
        else $error("Slow EEPROM half period wrong");
    ee_clk_run_a: assert property (
        state_r == PSL_LOAD && onchip_bus_speed_ctrl == BUS_SPEED_125 |-> ##[1:110] $changed(eeprom_serial_clock_o))
        else $error("EEPROM clock stalled");
    cs_gate_a: assert property (
        pin_sync_r[PIN_CS_N] |=> !host_access.rd && !host_access.cmd_addr)
        else $error("Access without chip select");

    strap_load_c: cover property (state_r == PSL_STRAP ##1 state_r == PSL_LOAD);
    ee_done_c: cover property ($rose(ee_done));
    wake_c: cover property (wake_event_out == power_mgmt_polarity);
    blink_c: cover property (act_lit ##1 !act_lit);
endmodule

// file: tb/psl_far_model.sv
/*
 * Far-side model: serial configuration memory on the data pin, with the pin's pull level.
 * Assumes the clock pin level is resolved by the bench and data is sampled on its rise.
 */
`timescale 1ns/100ps
module psl_far_model (
    input  wire logic        ee_clk,
    input  wire logic        serve,
    input  wire logic        pull,
    input  wire logic [15:0] rom_word,
    output logic             ee_data
);
    logic [3:0] idx_r;

    initial idx_r = 4'hf;

    // Next bit after each falling clock edge, so it stands steady over the rise
    always @(negedge ee_clk or negedge serve) begin
        if (!serve) begin
            idx_r <= 4'hf;
        end else begin
            idx_r <= idx_r - 4'h1;
        end
    end

    // Not serving: only the pull resistor sets the level, which is the strap
    assign ee_data = serve ? rom_word[idx_r] : pull;
endmodule

// file: tb/psl_pin_logic_test.sv
/*
 * Self-checking bench for the pin, status and strap logic.
 * Assumes a pull resistor sets every undriven pin and the blink count is cut to 16.
 */
`timescale 1ns/100ps
module psl_pin_logic_test;
    import psl_pkg::*;
    logic        clk_sys, rst, pol, ee_req, rd_n, cs_n, cmd, led_pull, dat_pull, clk_pull, serve, en;
    logic        a_o, a_oe_n, led_b, wake, irq_o, irq_oe_n, d_o, d_oe_n, d_pin, k_o, k_oe_n, ee_done;
    logic [15:0] cgc, irq, rom, ee_word;
    logic [3:0]  wev, wen;
    logic [1:0]  speed;
    psl_link_s   link;
    psl_strap_s  strap;
    psl_host_s   host;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          per;

    psl_pin_logic #(.BLINK_CYC(16)) psl_pin_logic_i (.clk_sys(clk_sys), .rst(rst), .clk_en(en),
        .link_status(link), .chip_global_control(cgc), .power_mgmt_polarity(pol), .wake_events(wev),
        .wake_enable(wen), .irq_status(irq), .onchip_bus_speed_ctrl(speed), .ee_load_req(ee_req),
        .port_indicator_a_i(a_oe_n ? led_pull : a_o), .port_indicator_a_o(a_o), .port_indicator_a_oe_n(a_oe_n),
        .port_indicator_b(led_b), .wake_event_out(wake), .host_irq_n_o(irq_o), .host_irq_n_oe_n(irq_oe_n),
        .read_strobe_n(rd_n), .chip_select_n(cs_n), .cmd_type(cmd), .eeprom_serial_data_i(d_pin),
        .eeprom_serial_data_o(d_o), .eeprom_serial_data_oe_n(d_oe_n),
        .eeprom_serial_clock_i(k_oe_n ? clk_pull : k_o), .eeprom_serial_clock_o(k_o),
        .eeprom_serial_clock_oe_n(k_oe_n), .strap(strap), .host_access(host), .ee_word(ee_word),
        .ee_done(ee_done));

    psl_far_model psl_far_model_i (.ee_clk(k_oe_n ? clk_pull : k_o), .serve(serve), .pull(dat_pull),
        .rom_word(rom), .ee_data(d_pin));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task cmp_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task do_reset(input logic la, input logic dl, input logic cl);
        led_pull = la;
        dat_pull = dl;
        clk_pull = cl;
        // Memory model off so the data pin shows only its pull level
        serve = 1'b0;
        rst = 1'b1;
        step(12);
        cmp_bit("wake_rst", 1'b1, wake);
        cmp_bit("irq_oe_rst", 1'b1, irq_oe_n);
        cmp_bit("led_a_oe_rst", 1'b1, a_oe_n);
        cmp_word("strap_rst", 16'h0000, 16'(strap));
        rst = 1'b0;
        step(6);
    endtask

    // Cycles from one rise of the serial clock to the next
    task period(output int c);
        int i;
        c = 0;
        for (i = 0; i < 3000 && k_o !== 1'b0; i++) step(1);
        for (i = 0; i < 3000 && k_o !== 1'b1; i++) step(1);
        while (k_o === 1'b1 && c < 3000) begin step(1); c++; end
        while (k_o === 1'b0 && c < 3000) begin step(1); c++; end
    endtask

    task wait_done;
        int i;
        for (i = 0; i < 20000 && ee_done !== 1'b1; i++) step(1);
        cmp_bit("ee_done", 1'b1, ee_done);
    endtask

    task final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Generous bound: two loads and the pin tests need about 19000 cycles
    initial begin
        #200000;
        n_mismatch++;
        final_report;
    end

    initial begin
        {rst, pol, ee_req, serve, cmd} = 5'h10;
        {rd_n, cs_n} = 2'h3;
        en = 1'b1;
        link = '0;
        {cgc, irq} = 32'h0;
        {wev, wen, speed} = 10'h0;
        rom = 16'ha5c3;
        do_reset(1'b1, 1'b1, 1'b0);
        serve = 1'b1;
        cmp_word("strap", 16'h0006, 16'(strap));
        cmp_bit("led_a_oe_n", 1'b0, a_oe_n);
        cmp_bit("ee_clk_oe_n", 1'b0, k_oe_n);
        period(per);
        cmp_word("ee_fast", 16'(800 / 4), 16'(per));
        wait_done;
        cmp_word("ee_word_fast", 16'ha5c3, ee_word);
        cmp_bit("ee_data_oe_n", 1'b1, d_oe_n);
        cmp_bit("ee_data_o", 1'b0, d_o);
        serve = 1'b0;
        step(4);
        cmp_word("strap_hold", 16'h0006, 16'(strap));
        rom = 16'h3c5a;
        speed = 2'h3;
        serve = 1'b1;
        ee_req = 1'b1;
        step(1);
        ee_req = 1'b0;
        step(2);
        cmp_bit("ee_done_clr", 1'b0, ee_done);
        period(per);
        cmp_word("ee_slow", 16'(4000 / 4), 16'(per));
        wait_done;
        cmp_word("ee_word_slow", 16'h3c5a, ee_word);
        link = '{up: 1'b1, speed_100: 1'b1, activity: 1'b0};
        step(2);
        cmp_bit("led_a_100", 1'b0, a_o);
        cmp_bit("led_b_link", 1'b0, led_b);
        link.speed_100 = 1'b0;
        step(2);
        cmp_bit("led_a_10", 1'b1, a_o);
        link.activity = 1'b1;
        step(1);
        link.activity = 1'b0;
        step(2);
        cmp_bit("led_b_blink", 1'b1, led_b);
        step(10);
        cmp_bit("led_b_back", 1'b0, led_b);
        cgc = 16'h0200;
        // Let the previous blink run out, a pulse during it is not restarted
        step(4);
        link.activity = 1'b1;
        step(1);
        link.activity = 1'b0;
        step(2);
        cmp_bit("led_a_act", 1'b0, a_o);
        cmp_bit("led_b_up", 1'b0, led_b);
        link.up = 1'b0;
        step(2);
        cmp_bit("led_b_down", 1'b1, led_b);
        wev = 4'h5;
        wen = 4'h2;
        step(2);
        cmp_bit("wake_masked", 1'b1, wake);
        wen = 4'h4;
        step(2);
        cmp_bit("wake_low", 1'b0, wake);
        pol = 1'b1;
        step(2);
        cmp_bit("wake_high", 1'b1, wake);
        en = 1'b0;
        irq = 16'h8000;
        step(2);
        cmp_bit("irq_frozen", 1'b1, irq_oe_n);
        en = 1'b1;
        step(2);
        cmp_bit("irq_oe_n", 1'b0, irq_oe_n);
        cmp_bit("irq_o", 1'b0, irq_o);
        irq = 16'h0000;
        step(2);
        cmp_bit("irq_release", 1'b1, irq_oe_n);
        rd_n = 1'b0;
        cmd = 1'b1;
        step(4);
        cmp_word("host_no_cs", 16'h0000, 16'(host));
        cs_n = 1'b0;
        step(4);
        cmp_word("host_rd_addr", 16'h0007, 16'(host));
        {rd_n, cmd} = 2'h2;
        step(4);
        cmp_word("host_sel", 16'h0004, 16'(host));
        do_reset(1'b0, 1'b0, 1'b1);
        cmp_word("strap_2nd", 16'h0001, 16'(strap));
        ee_req = 1'b1;
        step(1);
        ee_req = 1'b0;
        step(40);
        cmp_bit("no_load", 1'b0, ee_done);
        cmp_bit("no_clk", 1'b0, k_o);
        final_report;
    end
endmodule
